// ==== core/eiv_pkg.sv ====
// Behaviour
// - vector base is flash start, or boot start when vector select is set
// - interrupts blocked from unlock until after next instruction, else four cycles
// - blocking never alters the core global interrupt enable
// - unlock clears four cycles after set, or at the select write
// - boot lock bits block interrupts while running from the other section
// - pin activity triggers interrupts even when the pin is an output
// - enabled toggles on inputs 23:16, 14:8, 7:0 raise groups 2, 1, 0
// - per-pin mask registers choose which pins feed each group
// - pin changes also detected without the clock, for wake-up
// - low-level mode requests for as long as the line is low
// - edge detection runs on the clock and cannot wake from deep sleep
// - low level detected without the clock, for wake-up
// - a level gone before start-up ends wakes but gives no interrupt
// - sense code 00 low, 01 any change, 10 falling, 11 rising
// - line 1 needs global flag and mask; sense at bits 3:2
// - line 0 needs global flag and mask; sense at bits 1:0
// - line sampled before edge detection; pulses over one clock caught
// - mask bit 1 enables line 1, served at its own vector
// - line event sets flag; entry or write-one clears; zero in level mode
// - group change sets group flag; entry or write-one clears
// - each group has an enable gating it with the global flag
package eiv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PC_W   = 24;
  localparam int VEC_W  = 3;
  localparam logic [7:0] OFF_PC_FLAG   = 8'h3B;
  localparam logic [7:0] OFF_LINE_FLAG = 8'h3C;
  localparam logic [7:0] OFF_LINE_MASK = 8'h3D;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h55;
  localparam logic [7:0] OFF_PC_ENABLE = 8'h68;
  localparam logic [7:0] OFF_SENSE     = 8'h6A;
  localparam logic [7:0] OFF_PC_MASK0  = 8'h6B;
  localparam logic [7:0] OFF_PC_MASK1  = 8'h6C;
  localparam logic [7:0] OFF_PC_MASK2  = 8'h6D;
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_SELECT = 1;
  localparam int SENSE0_LSB = 0;
  localparam int SENSE1_LSB = 2;
  localparam logic [7:0] PC_MASK1_VALID = 8'h7F;
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
  typedef enum logic [1:0] {
    SENSE_LOW     = 2'b00,
    SENSE_CHANGE  = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING  = 2'b11
  } eiv_sense_type;
  localparam logic [2:0] VEC_LINE0  = 3'h0;
  localparam logic [2:0] VEC_LINE1  = 3'h1;
  localparam logic [2:0] VEC_GROUP0 = 3'h2;
  localparam logic [2:0] VEC_GROUP1 = 3'h3;
  localparam logic [2:0] VEC_GROUP2 = 3'h4;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wrEn;
    logic              rdEn;
  } eiv_bus_type;
endpackage

// ==== core/eiv_ext_irq.sv ====
`timescale 1ns/10ps
module eiv_ext_irq #(
  parameter int FLASH_AW = 16
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // register port, data-space addressing
  input  wire eiv_pkg::eiv_bus_type regReq,
  output logic [eiv_pkg::DATA_W-1:0] rdData_q,
  // pins
  input  wire logic [1:0]           extLinePin,
  input  wire logic [eiv_pkg::PC_W-1:0] pinChangeIn,
  // core side
  input  wire logic                 globalIntEnable,
  input  wire logic                 instrDone,
  input  wire logic                 intAck,
  input  wire logic [eiv_pkg::VEC_W-1:0] intAckVector,
  input  wire logic                 execInBoot,
  input  wire logic                 bootLockAppBit,
  input  wire logic                 bootLockBootBit,
  input  wire logic [FLASH_AW-1:0]  bootStartAddr,
  output logic                      irqValid_q,
  output logic [eiv_pkg::VEC_W-1:0] irqVector_q,
  output logic                      vectorTableSelect_q,
  output logic [FLASH_AW-1:0]       vectorBase_q,
  // clockless wake request for the sleep controller
  output logic                      wakeRequest
);
  import eiv_pkg::*;

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic [PC_W+1:0] syncA_q;
  logic [PC_W+1:0] syncB_q;
  logic [PC_W+1:0] prev_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      prev_q  <= '0;
    end else begin
      syncA_q <= {extLinePin, pinChangeIn};
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end

  function automatic logic senseHit(input logic [1:0] mode,
                                    input logic cur,
                                    input logic old);
    case (mode)
      SENSE_CHANGE:  senseHit = cur ^ old;
      SENSE_FALLING: senseHit = old & ~cur;
      SENSE_RISING:  senseHit = cur & ~old;
      default:       senseHit = 1'b0;
    endcase
  endfunction

  function automatic logic hitAddr(input logic [7:0] a,
                                   input logic [7:0] off);
    hitAddr = (a == off);
  endfunction

  // ------------------------------------------------------------
  // registers, flags and request
  // ------------------------------------------------------------
  logic [7:0] lineMask_q, lineMask_d;
  logic [7:0] sense_q, sense_d;
  logic [7:0] pcEnable_q, pcEnable_d;
  logic [7:0] pcMask0_q, pcMask0_d;
  logic [7:0] pcMask1_q, pcMask1_d;
  logic [7:0] pcMask2_q, pcMask2_d;
  logic [1:0] lineFlag_q, lineFlag_d;
  logic [2:0] pcFlag_q, pcFlag_d;
  logic [2:0] unlockCnt_q, unlockCnt_d;
  logic       postBlock_q, postBlock_d;
  logic       vector_table_select_d;
  logic [7:0] rdData_d;
  logic       irqValid_d;
  logic [2:0] irqVector_d;
  logic [FLASH_AW-1:0] vectorBase_d;
  logic [1:0] lineLow;
  logic [1:0] lineEvt;
  logic [2:0] pcEvt;
  logic [4:0] pend;
  logic       wr;
  logic       ctrlWr;
  logic       unlockSet;
  logic       selectWr;
  logic       blocked;
  logic [PC_W-1:0] pcMaskAll;

  assign wr        = regReq.wrEn;
  assign ctrlWr    = wr && hitAddr(regReq.addr, OFF_CORE_CTRL);
  assign unlockSet = ctrlWr && regReq.wdata[BIT_UNLOCK];
  // select taken only inside the open window with unlock zero
  assign selectWr  = ctrlWr && !regReq.wdata[BIT_UNLOCK] &&
                     (unlockCnt_q != 3'h0);
  assign pcMaskAll = {pcMask2_q, pcMask1_q & PC_MASK1_VALID, pcMask0_q};

  // gates only the request; the core's enable is untouched
  assign blocked = unlockSet || (unlockCnt_q != 3'h0) || postBlock_q ||
                   (vectorTableSelect_q && bootLockAppBit && !execInBoot) ||
                   (!vectorTableSelect_q && bootLockBootBit && execInBoot);

  // raw pins against last reference: no clock needed to see it
  assign wakeRequest = |((pinChangeIn ^ prev_q[PC_W-1:0]) & pcMaskAll)
    || (lineMask_q[0] && sense_q[1:0] == SENSE_LOW && !extLinePin[0])
    || (lineMask_q[1] && sense_q[3:2] == SENSE_LOW && !extLinePin[1]);

  always_comb begin
    lineLow[0] = !syncB_q[PC_W];
    lineLow[1] = !syncB_q[PC_W+1];
    lineEvt[0] = senseHit(sense_q[SENSE0_LSB +: 2], syncB_q[PC_W],
                          prev_q[PC_W]);
    lineEvt[1] = senseHit(sense_q[SENSE1_LSB +: 2], syncB_q[PC_W+1],
                          prev_q[PC_W+1]);
    pcEvt[0] = |((syncB_q[7:0] ^ prev_q[7:0]) & pcMaskAll[7:0]);
    pcEvt[1] = |((syncB_q[15:8] ^ prev_q[15:8]) & pcMaskAll[15:8]);
    pcEvt[2] = |((syncB_q[23:16] ^ prev_q[23:16]) &
                 pcMaskAll[23:16]);

    lineMask_d = lineMask_q;
    sense_d    = sense_q;
    pcEnable_d = pcEnable_q;
    pcMask0_d  = pcMask0_q;
    pcMask1_d  = pcMask1_q;
    pcMask2_d  = pcMask2_q;
    lineFlag_d = lineFlag_q;
    pcFlag_d   = pcFlag_q;
    vector_table_select_d    = vectorTableSelect_q;
    if (wr) begin
      if (hitAddr(regReq.addr, OFF_LINE_MASK)) begin
        lineMask_d = {6'h00, regReq.wdata[1:0]};
      end else if (hitAddr(regReq.addr, OFF_SENSE)) begin
        sense_d = {4'h0, regReq.wdata[3:0]};
      end else if (hitAddr(regReq.addr, OFF_PC_ENABLE)) begin
        pcEnable_d = {5'h00, regReq.wdata[2:0]};
      end else if (hitAddr(regReq.addr, OFF_PC_MASK0)) begin
        pcMask0_d = regReq.wdata;
      end else if (hitAddr(regReq.addr, OFF_PC_MASK1)) begin
        pcMask1_d = regReq.wdata & PC_MASK1_VALID;
      end else if (hitAddr(regReq.addr, OFF_PC_MASK2)) begin
        pcMask2_d = regReq.wdata;
      end else if (hitAddr(regReq.addr, OFF_LINE_FLAG)) begin
        lineFlag_d = lineFlag_q & ~regReq.wdata[1:0];
      end else if (hitAddr(regReq.addr, OFF_PC_FLAG)) begin
        pcFlag_d = pcFlag_q & ~regReq.wdata[2:0];
      end
    end
    if (intAck) begin
      if (intAckVector == VEC_LINE0) lineFlag_d[0] = 1'b0;
      if (intAckVector == VEC_LINE1) lineFlag_d[1] = 1'b0;
      if (intAckVector == VEC_GROUP0) pcFlag_d[0] = 1'b0;
      if (intAckVector == VEC_GROUP1) pcFlag_d[1] = 1'b0;
      if (intAckVector == VEC_GROUP2) pcFlag_d[2] = 1'b0;
    end
    // set wins over any clear in the same cycle
    lineFlag_d = lineFlag_d | lineEvt;
    pcFlag_d   = pcFlag_d | pcEvt;
    if (sense_q[1:0] == SENSE_LOW) lineFlag_d[0] = 1'b0;
    if (sense_q[3:2] == SENSE_LOW) lineFlag_d[1] = 1'b0;

    // unlock window and post-write hold
    unlockCnt_d = unlockCnt_q;
    postBlock_d = postBlock_q;
    if (unlockSet) begin
      unlockCnt_d = UNLOCK_CYCLES;
    end else if (selectWr) begin
      vector_table_select_d     = regReq.wdata[BIT_SELECT];
      unlockCnt_d = 3'h0;
      postBlock_d = 1'b1;
    end else if (unlockCnt_q != 3'h0) begin
      unlockCnt_d = unlockCnt_q - 3'h1;
    end
    if (postBlock_q && instrDone && !selectWr) postBlock_d = 1'b0;

    vectorBase_d = vector_table_select_d ? bootStartAddr : '0;

    // pending requests, highest priority first
    pend[0] = lineMask_q[0] &&
              (sense_q[1:0] == SENSE_LOW ? lineLow[0] : lineFlag_q[0]);
    pend[1] = lineMask_q[1] &&
              (sense_q[3:2] == SENSE_LOW ? lineLow[1] : lineFlag_q[1]);
    pend[2] = pcEnable_q[0] && pcFlag_q[0];
    pend[3] = pcEnable_q[1] && pcFlag_q[1];
    pend[4] = pcEnable_q[2] && pcFlag_q[2];
    irqValid_d  = globalIntEnable && !blocked && (|pend);
    irqVector_d = VEC_GROUP2;
    if (pend[0]) irqVector_d = VEC_LINE0;
    else if (pend[1]) irqVector_d = VEC_LINE1;
    else if (pend[2]) irqVector_d = VEC_GROUP0;
    else if (pend[3]) irqVector_d = VEC_GROUP1;

    rdData_d = RST_REG;
    if (regReq.rdEn) begin
      if (hitAddr(regReq.addr, OFF_LINE_MASK)) rdData_d = lineMask_q;
      else if (hitAddr(regReq.addr, OFF_SENSE)) rdData_d = sense_q;
      else if (hitAddr(regReq.addr, OFF_PC_ENABLE)) rdData_d = pcEnable_q;
      else if (hitAddr(regReq.addr, OFF_PC_MASK0)) rdData_d = pcMask0_q;
      else if (hitAddr(regReq.addr, OFF_PC_MASK1)) rdData_d = pcMask1_q;
      else if (hitAddr(regReq.addr, OFF_PC_MASK2)) rdData_d = pcMask2_q;
      else if (hitAddr(regReq.addr, OFF_LINE_FLAG))
        rdData_d = {6'h00, lineFlag_q};
      else if (hitAddr(regReq.addr, OFF_PC_FLAG))
        rdData_d = {5'h00, pcFlag_q};
      else if (hitAddr(regReq.addr, OFF_CORE_CTRL))
        rdData_d = {6'h00, vectorTableSelect_q, unlockCnt_q != 3'h0};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineMask_q          <= RST_REG;
      sense_q             <= RST_REG;
      pcEnable_q          <= RST_REG;
      pcMask0_q           <= RST_REG;
      pcMask1_q           <= RST_REG;
      pcMask2_q           <= RST_REG;
      lineFlag_q          <= '0;
      pcFlag_q            <= '0;
      unlockCnt_q         <= '0;
      postBlock_q         <= 1'b0;
      vectorTableSelect_q <= 1'b0;
      vectorBase_q        <= '0;
      irqValid_q          <= 1'b0;
      irqVector_q         <= '0;
      rdData_q            <= RST_REG;
    end else begin
      lineMask_q          <= lineMask_d;
      sense_q             <= sense_d;
      pcEnable_q          <= pcEnable_d;
      pcMask0_q           <= pcMask0_d;
      pcMask1_q           <= pcMask1_d;
      pcMask2_q           <= pcMask2_d;
      lineFlag_q          <= lineFlag_d;
      pcFlag_q            <= pcFlag_d;
      unlockCnt_q         <= unlockCnt_d;
      postBlock_q         <= postBlock_d;
      vectorTableSelect_q <= vector_table_select_d;
      vectorBase_q        <= vectorBase_d;
      irqValid_q          <= irqValid_d;
      irqVector_q         <= irqVector_d;
      rdData_q            <= rdData_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_unlock_load: assert property (
    unlockSet |=> unlockCnt_q == 3'h4)
    else $error("unlock window not loaded");
  chk_unlock_expire: assert property (
    (unlockSet ##1 !ctrlWr [*4]) |=> unlockCnt_q == 3'h0)
    else $error("unlock window outlived four cycles");
  chk_select_guard: assert property (
    vectorTableSelect_q != $past(vectorTableSelect_q) |->
      $past(selectWr))
    else $error("vector select changed without sequence");
  chk_block_irq: assert property (
    blocked |=> !irqValid_q)
    else $error("request while blocked");
  chk_global_gate: assert property (
    !globalIntEnable |=> !irqValid_q)
    else $error("request with global enable clear");
  chk_level_flag: assert property (
    sense_q[1:0] == SENSE_LOW |=> !lineFlag_q[0])
    else $error("line 0 flag set in level mode");
  chk_flag_set_wins: assert property (
    lineEvt[0] && sense_q[1:0] != SENSE_LOW |=> lineFlag_q[0])
    else $error("line 0 event lost");
  chk_group_flag: assert property (
    pcEvt[2] |=> pcFlag_q[2])
    else $error("group 2 change lost");
  chk_line_priority: assert property (
    irqValid_q && irqVector_q != VEC_LINE0 |-> !$past(pend[0]))
    else $error("line 0 not served first");
  chk_vector_base: assert property (
    vectorTableSelect_q |-> vectorBase_q == $past(bootStartAddr))
    else $error("vector base not boot start");
  chk_sync_delay: assert property (
    $past(reset_n, 2) |-> syncB_q[PC_W] == $past(extLinePin[0], 2))
    else $error("line 0 synchroniser depth wrong");
  chk_post_block: assert property (
    selectWr |=> postBlock_q && !irqValid_q)
    else $error("no hold after vector select write");
  chk_boot_lock: assert property (
    vectorTableSelect_q && bootLockAppBit && !execInBoot |=> !irqValid_q)
    else $error("request from application under boot lock");

  cov_select_move: cover property (selectWr ##1 vectorTableSelect_q);
  cov_boot_lock: cover property (vectorTableSelect_q && bootLockAppBit);
  cov_line0_irq: cover property (irqValid_q && irqVector_q == VEC_LINE0);
  cov_group2_irq: cover property (irqValid_q && irqVector_q == VEC_GROUP2);
endmodule

// ==== bench/eiv_pin_source.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// external sources on line and pin-change pins
// ----------------------------------------
module eiv_pin_source (
  // clock
  input  wire logic   sys_clk,
  // pins toward the block
  output logic [1:0]  extLinePin,
  output logic [23:0] pinChangeIn
);
  // lines idle high; pin-change inputs idle low
  initial begin
    extLinePin  = 2'h3;
    pinChangeIn = 24'h00_0000;
  end

  // a level stays until the bench moves it, past the instruction end
  task automatic setLines(input logic [1:0] v);
    @(posedge sys_clk);
    #2;
    extLinePin = v;
  endtask

  // the block may drive these pins as outputs; a toggle still counts
  task automatic togglePin(input int idx);
    @(posedge sys_clk);
    #2;
    pinChangeIn[idx] = ~pinChangeIn[idx];
  endtask
endmodule

// ==== bench/tb_external_interrupt_and_vector_select.sv ====
`timescale 1ns/10ps
module tb_external_interrupt_and_vector_select;
  import eiv_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } eiv_row_type;
  logic        sys_clk             = 1'b0;
  logic        reset_n             = 1'b0;
  eiv_bus_type regReq              = '0;
  logic        globalIntEnable     = 1'b0;
  logic        instrDone           = 1'b0;
  logic        intAck              = 1'b0;
  logic [2:0]  intAckVector        = 3'h0;
  logic        execInBoot          = 1'b0;
  logic        bootLockAppBit      = 1'b0;
  logic        bootLockBootBit     = 1'b0;
  logic [15:0] bootStartAddr       = 16'h1C00;
  logic [7:0]  rdData_q;
  logic [1:0]  extLinePin;
  logic [23:0] pinChangeIn;
  logic        irqValid_q;
  logic [2:0]  irqVector_q;
  logic        vectorTableSelect_q;
  logic [15:0] vectorBase_q;
  logic        wakeRequest;
  int          failures            = 0;
  int          checkCount          = 0;
  // reserved bits read zero; 0x40 is unmapped
  eiv_row_type rows [7] = '{'{8'h3D, 8'hFF, 8'h03}, '{8'h68, 8'hFF, 8'h07},
                            '{8'h6A, 8'hFF, 8'h0F}, '{8'h6B, 8'hFF, 8'hFF},
                            '{8'h6C, 8'hFF, 8'h7F}, '{8'h6D, 8'hFF, 8'hFF},
                            '{8'h40, 8'hFF, 8'h00}};

  always #12.5 sys_clk = ~sys_clk;

  eiv_ext_irq #(.FLASH_AW(16)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq),
    .rdData_q(rdData_q), .extLinePin(extLinePin),
    .pinChangeIn(pinChangeIn), .globalIntEnable(globalIntEnable),
    .instrDone(instrDone), .intAck(intAck), .intAckVector(intAckVector),
    .execInBoot(execInBoot), .bootLockAppBit(bootLockAppBit),
    .bootLockBootBit(bootLockBootBit), .bootStartAddr(bootStartAddr),
    .irqValid_q(irqValid_q), .irqVector_q(irqVector_q),
    .vectorTableSelect_q(vectorTableSelect_q),
    .vectorBase_q(vectorBase_q), .wakeRequest(wakeRequest));

  eiv_pin_source src_u (
    .sys_clk(sys_clk), .extLinePin(extLinePin), .pinChangeIn(pinChangeIn));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #2;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    regReq = '{a, d, 1'b1, 1'b0};
    step(1);
    regReq.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step(1);
    regReq = '{a, 8'h00, 1'b0, 1'b1};
    step(1);
    regReq.rdEn = 1'b0;
    chk(32'(rdData_q), 32'(exp));
  endtask

  task automatic ack(input logic [2:0] v);
    step(1);
    intAck = 1'b1;
    intAckVector = v;
    step(1);
    intAck = 1'b0;
  endtask

  // bounded wait: a request that never comes is a mismatch
  task automatic expectIrq(input logic exp, input logic [2:0] vec);
    int n;
    n = 0;
    while (n < 8 && irqValid_q !== 1'b1) begin
      step(1);
      n++;
    end
    chk(32'(irqValid_q), 32'(exp));
    if (exp) begin
      chk(32'(irqVector_q), 32'(vec));
    end
  endtask

  task automatic lineTest(input int l, input logic [1:0] m);
    wr(OFF_LINE_MASK, 8'(1 << l));
    wr(OFF_SENSE, 8'(m) << (2 * l));
    wr(OFF_LINE_FLAG, 8'h03);
    src_u.setLines(2'h3 ^ 2'(1 << l));
    #1;
    if (m == 2'h0) chk(32'(wakeRequest), 32'h1);
    expectIrq(m != 2'h3, 3'(l));
    if (m == 2'h0) begin
      rd(OFF_LINE_FLAG, 8'h00);
      chk(32'(irqValid_q), 32'h1);
    end
    if (m != 2'h0) ack(3'(l));
    step(3);
    src_u.setLines(2'h3);
    if (m == 2'h0) step(5);
    expectIrq(m[0], 3'(l));
    wr(OFF_LINE_FLAG, 8'h03);
    step(3);
    chk(32'(irqValid_q), 32'h0);
  endtask

  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    conclude();
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].addr, 8'h00);
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
      wr(rows[i].addr, 8'h00);
    end
    endTest("registers");
    globalIntEnable = 1'b1;
    for (int l = 0; l < 2; l++) begin
      for (int m = 0; m < 4; m++) begin
        lineTest(l, 2'(m));
      end
    end
    endTest("sense modes");
    globalIntEnable = 1'b0;
    wr(OFF_LINE_MASK, 8'h03);
    wr(OFF_SENSE, 8'h0F);
    src_u.setLines(2'h0);
    step(4);
    src_u.setLines(2'h3);
    expectIrq(1'b0, 3'h0);
    globalIntEnable = 1'b1;
    expectIrq(1'b1, VEC_LINE0);
    ack(VEC_LINE0);
    step(3);
    expectIrq(1'b1, VEC_LINE1);
    ack(VEC_LINE1);
    endTest("priority");
    wr(OFF_LINE_MASK, 8'h00);
    wr(OFF_PC_ENABLE, 8'h07);
    for (int g = 0; g < 3; g++) begin
      wr(OFF_PC_MASK0 + 8'(g), 8'h08);
      src_u.togglePin(g * 8 + 2);
      #1;
      chk(32'(wakeRequest), 32'h0);
      expectIrq(1'b0, 3'h0);
      src_u.togglePin(g * 8 + 3);
      #1;
      chk(32'(wakeRequest), 32'h1);
      expectIrq(1'b1, VEC_GROUP0 + 3'(g));
      rd(OFF_PC_FLAG, 8'(1 << g));
      wr(OFF_PC_FLAG, 8'(1 << g));
      step(3);
      chk(32'(irqValid_q), 32'h0);
      wr(OFF_PC_MASK0 + 8'(g), 8'h00);
    end
    endTest("pin change");
    wr(OFF_LINE_MASK, 8'h01);
    wr(OFF_SENSE, 8'h00);
    src_u.setLines(2'h2);
    expectIrq(1'b1, VEC_LINE0);
    wr(OFF_CORE_CTRL, 8'h01);
    rd(OFF_CORE_CTRL, 8'h01);
    chk(32'(irqValid_q), 32'h0);
    wr(OFF_CORE_CTRL, 8'h02);
    step(1);
    chk(32'(vectorTableSelect_q), 32'h1);
    chk(32'(vectorBase_q), 32'(bootStartAddr));
    chk(32'(irqValid_q), 32'h0);
    step(1);
    instrDone = 1'b1;
    step(1);
    instrDone = 1'b0;
    expectIrq(1'b1, VEC_LINE0);
    bootLockAppBit = 1'b1;
    step(3);
    chk(32'(irqValid_q), 32'h0);
    execInBoot = 1'b1;
    expectIrq(1'b1, VEC_LINE0);
    wr(OFF_CORE_CTRL, 8'h01);
    step(6);
    chk(32'(irqValid_q), 32'h1);
    wr(OFF_CORE_CTRL, 8'h00);
    rd(OFF_CORE_CTRL, 8'h02);
    endTest("vector move");
    reset_n = 1'b0;
    step(2);
    chk(32'(vectorTableSelect_q), 32'h0);
    chk(32'(vectorBase_q), 32'h0);
    chk(32'(irqValid_q), 32'h0);
    reset_n = 1'b1;
    rd(OFF_LINE_MASK, 8'h00);
    bootLockBootBit = 1'b1;
    wr(OFF_LINE_MASK, 8'h01);
    step(3);
    chk(32'(irqValid_q), 32'h0);
    execInBoot = 1'b0;
    expectIrq(1'b1, VEC_LINE0);
    endTest("reset");
    conclude();
  end
endmodule
